// *** hdl/usb_port_cfg.svh ***
// named constants for the host root-port block: offsets, field positions, codes, times
// assumes a 100 MHz system clock and a byte-addressed Avalon-MM register window
`ifndef USB_PORT_CFG_SVH
`define USB_PORT_CFG_SVH

// register byte offsets
`define OFS_ROLE        4'h0
`define OFS_STATUS      4'h4
`define OFS_INT_EN      4'h8
`define OFS_PORT        4'hc

// role select codes, field width two bits
`define ROLE_IDLE       2'h0
`define ROLE_DEVICE     2'h2
`define ROLE_HOST       2'h3

// status and interrupt enable bit positions
`define STS_PORT_CHG    2
`define STS_SOF         7

// port status/control bit positions
`define PSC_CONNECT     0
`define PSC_CONN_CHG    1
`define PSC_ENABLED     2
`define PSC_EN_CHG      3
`define PSC_RESET       8
`define PSC_HIGH_SPEED  9
`define PSC_OWNER       13
`define PSC_SPEED_LO    26
`define PSC_SPEED_HI    27
`define PSC_PHY_LO      30
`define PSC_PHY_HI      31

// speed field encodings
`define SPEED_FULL      2'h0
`define SPEED_LOW       2'h1
`define SPEED_HIGH      2'h2

// reset values
`define PHY_MODE_RST    2'h0

// times in ns and the clock period in ns
`define CLK_PERIOD_NS   10
`define SOF_PERIOD_NS   125000
`define PORT_RESET_NS   10000000

`endif

// *** hdl/usb_port_pkg.sv ***
// types shared by the root-port block and its interval timer
// assumes usb_port_cfg.svh supplies the numeric constants
package usb_port_pkg;

	// pin-side sense inputs from the transceiver
	typedef struct packed {
		logic attach;
		logic hs_chirp_ok;
		logic ls_detect;
	} link_in_t;

	// interval timer state
	typedef struct packed {
		logic [19:0] count;
		logic        done;
	} timer_state_t;

	// root-port block state
	typedef struct packed {
		link_in_t    sync1;
		link_in_t    sync2;
		logic        attach_prev;
		logic [1:0]  role;
		logic        sof_flag;
		logic        port_chg_flag;
		logic        sof_en;
		logic        port_chg_en;
		logic        conn_chg;
		logic        port_en;
		logic        en_chg;
		logic        reset_active;
		logic [1:0]  speed;
		logic [1:0]  phy_mode;
		logic        waitreq;
		logic [31:0] rdata;
		logic        irq;
		logic        sof_pulse;
		logic        host_role;
	} port_state_t;

endpackage

// *** hdl/interval_timer.sv ***
// interval timer: counts clock cycles while run is high, pulses done at the end
// assumes run comes from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module interval_timer #(
	parameter logic [19:0] COUNT = 20'h00001
) (
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic run_in,
	output logic      done_out
);
	usb_port_pkg::timer_state_t st_ff;
	usb_port_pkg::timer_state_t nxt_st;

	// restart from zero whenever run drops, so every interval is whole
	always_comb begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		if (!run_in) begin
			nxt_st.count = 20'h00000;
		end else if (st_ff.count == COUNT - 20'h00001) begin
			nxt_st.count = 20'h00000;
			nxt_st.done = 1'b1;
		end else begin
			nxt_st.count = st_ff.count + 20'h00001;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign done_out = st_ff.done; // straight from a flop
endmodule
`default_nettype wire

// *** hdl/usb_host_port.sv ***
// host root-port control: role select, sof time base, timed port reset, speed report
// assumes an Avalon-MM master on clk_in and asynchronous sense pins from the transceiver
//
// Our own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "usb_port_cfg.svh"
module usb_host_port #(
	parameter logic [19:0] SOF_CYCLES   = 20'(`SOF_PERIOD_NS / `CLK_PERIOD_NS),
	parameter logic [19:0] RESET_CYCLES = 20'(`PORT_RESET_NS / `CLK_PERIOD_NS)
) (
	input  wire logic                   clk_in,
	input  wire logic                   rst_n_in,
	input  wire logic [3:0]             avs_address_in,
	input  wire logic                   avs_read_in,
	input  wire logic                   avs_write_in,
	input  wire logic [31:0]            avs_writedata_in,
	input  wire logic [3:0]             avs_byteenable_in,
	output logic [31:0]                 avs_readdata_out,
	output logic                        avs_waitrequest_out,
	input  wire usb_port_pkg::link_in_t link_in,
	output logic                        port_reset_out,
	output logic                        sof_pulse_out,
	output logic                        event_irq_out,
	output logic [1:0]                  phy_mode_out,
	output logic                        host_role_out
);
	usb_port_pkg::port_state_t st_ff;
	usb_port_pkg::port_state_t nxt_st;

	logic        sof_done;
	logic        reset_done;
	logic        host;
	logic        wr_acc;
	logic        rd_setup;
	logic        attach_chg;
	logic        start_reset;
	logic [31:0] wmask;
	logic [31:0] wd;
	logic [31:0] rd;
	logic [1:0]  new_speed;
	logic [31:0] role_word;
	logic [31:0] port_word;
	logic        wr_role;
	logic        wr_status;
	logic        wr_int_en;
	logic        wr_port;

	// byte enables widened to a bit mask
	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	// keep unwritten lanes, take written ones
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m,
			input logic [31:0] d);
		merge = (old & ~m) | (d & m);
	endfunction

	// sticky flag: a set in the same cycle beats a one-to-clear
	function automatic logic sticky(input logic old, input logic set, input logic clr);
		sticky = set | (old & ~clr);
	endfunction

	// microframe time base, runs only in host role
	interval_timer #(
		.COUNT (SOF_CYCLES)
	) sof_timer (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.run_in   (host),
		.done_out (sof_done)
	);

	// port reset duration, runs while a reset is in progress
	interval_timer #(
		.COUNT (RESET_CYCLES)
	) reset_timer (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.run_in   (st_ff.reset_active),
		.done_out (reset_done)
	);

	// bus handshake terms and write lanes
	always_comb begin
		host = (st_ff.role == `ROLE_HOST);
		wr_acc = avs_write_in && !st_ff.waitreq;
		rd_setup = avs_read_in && st_ff.waitreq;
		wmask = lane_mask(avs_byteenable_in);
		wd = avs_writedata_in & wmask;
		attach_chg = st_ff.sync2.attach != st_ff.attach_prev;
	end

	// accepted write strobes per register; start_reset decodes the port offset again on its own
	always_comb begin
		wr_role = wr_acc && (avs_address_in == `OFS_ROLE);
		wr_status = wr_acc && (avs_address_in == `OFS_STATUS);
		wr_int_en = wr_acc && (avs_address_in == `OFS_INT_EN);
		wr_port = wr_acc && (avs_address_in == `OFS_PORT);
	end

	// merged words for the writable fields; a call result cannot be sliced directly
	always_comb begin
		role_word = merge({30'h0, st_ff.role}, wmask, wd);
		port_word = merge({st_ff.phy_mode, 30'h0}, wmask, wd);
	end

	// negotiated speed, sampled when the reset times out
	always_comb begin
		if (st_ff.sync2.hs_chirp_ok) begin
			new_speed = `SPEED_HIGH;
		end else if (st_ff.sync2.ls_detect) begin
			new_speed = `SPEED_LOW;
		end else begin
			new_speed = `SPEED_FULL;
		end
	end

	// reset only starts in host role with a device attached and none running
	always_comb begin
		start_reset = wr_acc && (avs_address_in == `OFS_PORT) && wd[`PSC_RESET] && host
			&& st_ff.sync2.attach && !st_ff.reset_active;
	end

	// read word; reserved bits read as zero, owner bit always zero
	always_comb begin
		rd = 32'h0000_0000;
		unique case (avs_address_in)
			`OFS_ROLE: begin
				rd[1:0] = st_ff.role;
			end
			`OFS_STATUS: begin
				rd[`STS_PORT_CHG] = st_ff.port_chg_flag;
				rd[`STS_SOF] = st_ff.sof_flag;
			end
			`OFS_INT_EN: begin
				rd[`STS_PORT_CHG] = st_ff.port_chg_en;
				rd[`STS_SOF] = st_ff.sof_en;
			end
			`OFS_PORT: begin
				rd[`PSC_CONNECT] = st_ff.sync2.attach;
				rd[`PSC_CONN_CHG] = st_ff.conn_chg;
				rd[`PSC_ENABLED] = st_ff.port_en;
				rd[`PSC_EN_CHG] = st_ff.en_chg;
				rd[`PSC_RESET] = st_ff.reset_active;
				rd[`PSC_HIGH_SPEED] = (st_ff.speed == `SPEED_HIGH);
				rd[`PSC_OWNER] = 1'b0;
				rd[`PSC_SPEED_HI:`PSC_SPEED_LO] = st_ff.speed;
				rd[`PSC_PHY_HI:`PSC_PHY_LO] = st_ff.phy_mode;
			end
			default: begin
				rd = 32'h0000_0000; // unmapped offsets read zero
			end
		endcase
	end

	// next state of the whole block
	always_comb begin
		nxt_st = st_ff;

		// two-stage sense synchronisers; only the second stage is used
		nxt_st.sync1 = link_in;
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.attach_prev = st_ff.sync2.attach;

		// one wait cycle, then the answer; waitrequest rises again after acceptance
		nxt_st.waitreq = !((avs_read_in || avs_write_in) && st_ff.waitreq);
		if (rd_setup) begin
			nxt_st.rdata = rd;
		end

		// role select, plain read/write
		if (wr_role) begin
			nxt_st.role = role_word[1:0];
		end

		// interrupt enables, one sof enable for both roles
		if (wr_int_en) begin
			nxt_st.sof_en = wd[`STS_SOF] | (st_ff.sof_en & ~wmask[`STS_SOF]);
			nxt_st.port_chg_en = wd[`STS_PORT_CHG]
				| (st_ff.port_chg_en & ~wmask[`STS_PORT_CHG]);
		end

		// phy mode bits steer the transceiver interface
		if (wr_port) begin
			nxt_st.phy_mode = port_word[31:30];
		end

		// connect change on any attach edge, cleared by one-to-clear
		nxt_st.conn_chg = sticky(st_ff.conn_chg, attach_chg,
			wr_port && wd[`PSC_CONN_CHG]);

		// start a timed reset; a written zero has no clear path
		if (start_reset) begin
			nxt_st.reset_active = 1'b1;
			nxt_st.port_en = 1'b0;
		end

		// reset expiry: self-clear, enable regardless of chirp, latch speed
		if (reset_done && st_ff.reset_active) begin
			nxt_st.reset_active = 1'b0;
			nxt_st.port_en = 1'b1;
			nxt_st.speed = new_speed;
		end

		// detach drops the port enable without flagging an enable change
		if (!st_ff.sync2.attach && !st_ff.reset_active) begin
			nxt_st.port_en = 1'b0;
		end

		// enable change flag, set wins over clear
		nxt_st.en_chg = sticky(st_ff.en_chg, reset_done && st_ff.reset_active,
			wr_port && wd[`PSC_EN_CHG]);

		// port change summary flag in status
		nxt_st.port_chg_flag = sticky(st_ff.port_chg_flag,
			attach_chg || (reset_done && st_ff.reset_active),
			wr_status && wd[`STS_PORT_CHG]);

		// free-running microframe event, host role only, fixed period
		nxt_st.sof_pulse = sof_done && host;
		nxt_st.sof_flag = sticky(st_ff.sof_flag, sof_done && host,
			wr_status && wd[`STS_SOF]);

		// leaving host role abandons any reset in flight
		if (!host) begin
			nxt_st.reset_active = 1'b0;
		end

		// role decode registered so the role output comes from a flop
		nxt_st.host_role = (nxt_st.role == `ROLE_HOST);

		// event output from the next flag values, so it lines up with the flags
		nxt_st.irq = (nxt_st.sof_flag && nxt_st.sof_en)
			|| (nxt_st.port_chg_flag && nxt_st.port_chg_en);
	end

	// single state register
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			st_ff <= '0;
			st_ff.role <= `ROLE_IDLE;
			st_ff.phy_mode <= `PHY_MODE_RST;
			st_ff.speed <= `SPEED_FULL;
			st_ff.waitreq <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// outputs straight from the state register
	assign avs_readdata_out = st_ff.rdata;
	assign avs_waitrequest_out = st_ff.waitreq;
	assign port_reset_out = st_ff.reset_active;
	assign sof_pulse_out = st_ff.sof_pulse;
	assign event_irq_out = st_ff.irq;
	assign phy_mode_out = st_ff.phy_mode;
	assign host_role_out = st_ff.host_role;
endmodule
`default_nettype wire

// *** bench/usb_dev_model.sv ***
// plug-in device model on the root port: attach, chirp and low-speed sense
// assumes the bench decides when the device is plugged and what it can do
`timescale 1ns/1ps
`default_nettype none
module usb_dev_model (
	input  wire logic                   clk_in,
	input  wire logic                   plug_in,
	input  wire logic                   hs_cap_in,
	input  wire logic                   ls_cap_in,
	input  wire logic                   bus_reset_in,
	output wire usb_port_pkg::link_in_t link_out
);
	logic chirp_ff;
	// chirp answered only once a bus reset is seen, lost on unplug
	always_ff @(posedge clk_in) begin
		chirp_ff <= plug_in && hs_cap_in && (chirp_ff || bus_reset_in);
	end
	// non-high-speed devices stay on the root port
	assign link_out = '{plug_in, chirp_ff, plug_in && ls_cap_in};
endmodule
`default_nettype wire

// *** bench/usb_host_port_chk.sv ***
// checker for the root-port block: bus pacing, sof spacing, timed reset
// assumes it is bound to usb_host_port and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module usb_host_port_chk #(
	parameter logic [19:0] SOF_CYCLES   = 20'h00014,
	parameter logic [19:0] RESET_CYCLES = 20'h0001e
) (
	input wire logic        clk_in,
	input wire logic        rst_n_in,
	input wire logic [3:0]  avs_address_in,
	input wire logic        avs_read_in,
	input wire logic        avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic        avs_waitrequest_out,
	input wire logic        port_reset_out,
	input wire logic        sof_pulse_out,
	input wire logic [1:0]  phy_mode_out,
	input wire logic        host_role_out
);
	logic [19:0] gap_ff;
	logic [19:0] len_ff;
	logic        seen_ff;
	logic        acc;
	assign acc = avs_write_in && !avs_waitrequest_out && avs_address_in == 4'hc;
	// spacing since last sof, high time of bus reset
	always_ff @(posedge clk_in) begin
		gap_ff <= sof_pulse_out ? 20'h00001 : gap_ff + 20'h00001;
		seen_ff <= rst_n_in && host_role_out && (seen_ff || sof_pulse_out);
		len_ff <= port_reset_out ? len_ff + 20'h00001 : 20'h00000;
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	a_sof_spacing: assert property (sof_pulse_out && seen_ff |-> gap_ff == SOF_CYCLES)
		else $error("sof spacing wrong");
	a_sof_host_only: assert property (sof_pulse_out |-> $past(host_role_out))
		else $error("sof outside host role");
	a_reset_length: assert property ($fell(port_reset_out) && host_role_out
		|-> len_ff == RESET_CYCLES + 20'h00001)
		else $error("bus reset length wrong");
	a_reset_host_only: assert property ($rose(port_reset_out) |-> host_role_out)
		else $error("bus reset outside host role");
	a_wait_once: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out)
		else $error("request not answered");
	a_wait_pulse: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low too long");
	a_phy_by_write: assert property (!$stable(phy_mode_out) |-> $past(acc))
		else $error("phy mode moved without write");
	a_zero_ignored: assert property (port_reset_out && acc && !avs_writedata_in[8]
		&& len_ff < RESET_CYCLES - 20'h00002 |=> port_reset_out)
		else $error("zero write cut bus reset");
endmodule
bind usb_host_port usb_host_port_chk #(
	.SOF_CYCLES(SOF_CYCLES),
	.RESET_CYCLES(RESET_CYCLES)
) chk_i (
	.clk_in(clk_in),
	.rst_n_in(rst_n_in),
	.avs_address_in(avs_address_in),
	.avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in),
	.avs_writedata_in(avs_writedata_in),
	.avs_waitrequest_out(avs_waitrequest_out),
	.port_reset_out(port_reset_out),
	.sof_pulse_out(sof_pulse_out),
	.phy_mode_out(phy_mode_out),
	.host_role_out(host_role_out)
);
`default_nettype wire

// *** bench/tb_usb_host_port.sv ***
// self-checking bench for the root-port block with a plug-in device model
// assumes short sof and reset counts so the run stays brief
`timescale 1ns/1ps
`default_nettype none
`include "usb_port_cfg.svh"
module tb_usb_host_port;
	logic                   clk_in;
	logic                   rst_n_in;
	logic [3:0]             adr = 4'h0;
	logic                   rd = 1'b0;
	logic                   wr = 1'b0;
	logic [31:0]            wd = 32'h0;
	logic [31:0]            rdat;
	logic                   wait_o;
	logic                   plug = 1'b0;
	logic                   hs = 1'b0;
	logic                   ls = 1'b0;
	usb_port_pkg::link_in_t link;
	logic                   bus_rst;
	logic                   sof;
	logic                   irq;
	logic [1:0]             phy;
	logic                   host;
	int                     fail_count = 0;
	int                     comparisons = 0;
	usb_host_port #(.SOF_CYCLES(20'h00014), .RESET_CYCLES(20'h0001e)) dut (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(adr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
		.avs_byteenable_in(4'hf), .avs_readdata_out(rdat),
		.avs_waitrequest_out(wait_o), .link_in(link), .port_reset_out(bus_rst),
		.sof_pulse_out(sof), .event_irq_out(irq), .phy_mode_out(phy),
		.host_role_out(host));
	usb_dev_model dev (.clk_in(clk_in), .plug_in(plug), .hs_cap_in(hs),
		.ls_cap_in(ls), .bus_reset_in(bus_rst), .link_out(link));
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// one bus access; held until waitrequest is seen low, bounded
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
			output logic [31:0] q);
		int n;
		@(posedge clk_in);
		wr <= w;
		rd <= !w;
		adr <= a;
		wd <= d;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (wait_o !== 1'b0 && n < 50);
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		if (wait_o !== 1'b0) begin
			fail_count++;
			results();
		end
	endtask
	task automatic t_regs();
		logic [31:0] q;
		bus(1'b0, `OFS_ROLE, 32'h0, q);
		chk(q & 32'h3, 32'h0);
		bus(1'b1, `OFS_PORT, 32'h8000_2000, q);
		bus(1'b0, `OFS_PORT, 32'h0, q);
		chk(q & 32'hc000_2000, 32'h8000_0000);
		chk(32'(phy), 32'h2);
		bus(1'b0, 4'h1, 32'h0, q);
		chk(q, 32'h0);
	endtask
	// bus reset refused while no role is chosen
	task automatic t_idle();
		logic [31:0] q;
		plug <= 1'b1;
		repeat (8) @(posedge clk_in);
		bus(1'b1, `OFS_PORT, 32'h100, q);
		repeat (3) @(posedge clk_in);
		chk(32'(bus_rst), 32'h0);
	endtask
	task automatic t_attach(input int s);
		logic [31:0] q;
		int n;
		plug <= 1'b0;
		repeat (8) @(posedge clk_in);
		bus(1'b1, `OFS_PORT, 32'ha, q);
		bus(1'b1, `OFS_STATUS, 32'h84, q);
		hs <= (s == 2);
		ls <= (s == 1);
		plug <= 1'b1;
		repeat (8) @(posedge clk_in);
		chk(32'(irq), 32'h1);
		bus(1'b0, `OFS_PORT, 32'h0, q);
		chk(q & 32'h3, 32'h3);
		bus(1'b1, `OFS_PORT, 32'h2, q);
		bus(1'b1, `OFS_STATUS, 32'h4, q);
		repeat (2) @(posedge clk_in);
		chk(32'(irq), 32'h0);
		bus(1'b1, `OFS_PORT, 32'h100, q);
		bus(1'b1, `OFS_PORT, 32'h0, q);
		chk(32'(bus_rst), 32'h1);
		n = 0;
		while (bus_rst !== 1'b0 && n < 100) begin
			@(posedge clk_in);
			n++;
		end
		if (bus_rst !== 1'b0) begin
			fail_count++;
			results();
		end
		repeat (3) @(posedge clk_in);
		chk(32'(irq), 32'h1);
		bus(1'b0, `OFS_PORT, 32'h0, q);
		chk(q & 32'h0c00_230f, 32'(s) << 26 | 32'(s == 2) << 9 | 32'hd);
	endtask
	task automatic t_sof();
		logic [31:0] q;
		int n;
		bus(1'b1, `OFS_INT_EN, 32'h80, q);
		bus(1'b1, `OFS_STATUS, 32'h84, q);
		n = 0;
		while (sof !== 1'b1 && n < 40) begin
			@(posedge clk_in);
			n++;
		end
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (sof !== 1'b1 && n < 40);
		chk(32'(n), 32'h14);
		repeat (3) @(posedge clk_in);
		chk(32'(irq), 32'h1);
		bus(1'b0, `OFS_STATUS, 32'h0, q);
		chk(q & 32'h80, 32'h80);
	endtask
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// reset, then the scenarios in turn
	initial begin
		logic [31:0] q;
		rst_n_in = 1'b0;
		repeat (6) @(posedge clk_in);
		rst_n_in <= 1'b1;
		t_regs();
		t_idle();
		bus(1'b1, `OFS_ROLE, 32'h3, q);
		bus(1'b1, `OFS_INT_EN, 32'h4, q);
		chk(32'(host), 32'h1);
		for (int s = 0; s < 3; s++) begin
			t_attach(s);
		end
		t_sof();
		results();
	end
endmodule
`default_nettype wire
